// File: nfsb_pkg.sv
package nfsb_pkg;
    typedef enum logic [1:0] {NFSB_OP, NFSB_ADR, NFSB_DAT, NFSB_DONE}
        nfsb_phase_type;
endpackage : nfsb_pkg

// File: nfsb_regs.svh
`ifndef NFSB_REGS_SVH
`define NFSB_REGS_SVH
`define NFSB_ADDR_PROT 12'h000
`define NFSB_ADDR_FEAT 12'h004
`define NFSB_ADDR_STAT 12'h008
`define NFSB_ADDR_EVT 12'h00C
`define NFSB_ADDR_FADR 12'h010
`define NFSB_ADDR_IRQS 12'h014
`define NFSB_ADDR_IRQM 12'h018
`define NFSB_FA_PROT 8'hA0
`define NFSB_FA_FEAT 8'hB0
`define NFSB_FA_STAT 8'hC0
`define NFSB_FA_STAT2 8'hF0
`define NFSB_OP_GETF 8'h0F
`define NFSB_OP_SETF 8'h1F
`define NFSB_OP_SRST 8'hFF
`define NFSB_OP_PEXE 8'h10
`define NFSB_OP_BERS 8'hD8
`define NFSB_OP_PRD 8'h13
`define NFSB_PROT_RST 8'h38
`define NFSB_FEAT_RST 8'h10
`define NFSB_PROT_MASK 8'hBE
`define NFSB_FEAT_MASK 8'hD1
`define NFSB_BIT_LOCK 7
`define NFSB_BIT_QE 0
`define NFSB_BIT_ECC 4
`define NFSB_BIT_PFAIL 3
`define NFSB_BIT_EFAIL 2
`endif

// File: nfsb_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module nfsb_spi_host (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso
);
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    task automatic xfer(input logic [23:0] f, input int n,
        output logic [7:0] rd);
        #13 o_cs_n = 1'b0;
        for (int i = 0; i < n * 8; i++)
        begin
            o_mosi = f[23 - i];
            #160 o_sclk = 1'b1;
            #140 rd = {rd[6:0], i_miso};
            #20 o_sclk = 1'b0;
        end
        #160 o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        #400;
    endtask : xfer
endmodule : nfsb_spi_host
`default_nettype wire

// File: nfsb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "nfsb_regs.svh"
// Behaviour
// R1: lock bit with wp low blocks protect writes
// R2: protection levels power up ones, others zero
// R3: otp bits power up zero, soft reset keeps
// R4: ecc enable powers up one
// R5: host may clear ecc enable
// R6: quad ops only while quad enable set
// R7: ecc status zeroed on reset, read start
// R8: ecc status loaded after valid read
// R9: ecc status meaningless when ecc disabled
// R10: power-on ecc status from page zero
// R11: program fail sets flag, powers up zero
// R12: protected program attempt sets program fail
// R13: program execute or reset clears program fail
// R14: erase failure or locked erase sets flag
// R15: erase start or reset clears erase fail
// R16: feature read returns addressed status byte
// R17: host writes reserved bits as zero
// R18: quad enable at bit zero of b0
module nfsb_top import nfsb_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    input wire logic i_wp_n,
    output logic o_miso,
    output logic o_miso_oe,
    input wire logic i_prog_fail,
    input wire logic i_prot_prog,
    input wire logic i_erase_fail,
    input wire logic i_locked_erase,
    input wire logic i_read_done,
    input wire logic [3:0] i_read_result,
    input wire logic i_quad_req,
    output logic o_quad_grant,
    output logic o_ecc_active,
    output logic o_irq
);
    logic [2:0] sclk_s, cs_s, mosi_s, wp_s;
    logic [7:0] prot;
    logic [7:0] feat;
    logic [3:0] eccst;
    logic pfail, efail;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic [7:0] opc, fadr, txbyte;
    nfsb_phase_type phase;
    logic [4:0] irqs, irqm;
    logic [7:0] host_fadr;
    logic por_done;

    // two-flop sync of pins
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sclk_s <= 3'h0;
            cs_s <= 3'h7;
            mosi_s <= 3'h0;
            wp_s <= 3'h7;
        end
        else
        begin
            sclk_s <= {sclk_s[1:0], i_sclk};
            cs_s <= {cs_s[1:0], i_cs_n};
            mosi_s <= {mosi_s[1:0], i_mosi};
            wp_s <= {wp_s[1:0], i_wp_n};
        end
    end

    wire rise = sclk_s[1] & ~sclk_s[2];
    wire fall = ~sclk_s[1] & sclk_s[2];
    wire sel = ~cs_s[1];
    wire [7:0] nbyte = {shreg[6:0], mosi_s[1]};
    wire byte_end = sel & rise & (bitcnt == 3'h7);
    wire op_end = byte_end & (phase == NFSB_OP);
    wire soft_rst = op_end & (nbyte == `NFSB_OP_SRST);
    wire pexe = op_end & (nbyte == `NFSB_OP_PEXE);
    wire bers = op_end & (nbyte == `NFSB_OP_BERS);
    wire prd = op_end & (nbyte == `NFSB_OP_PRD);
    wire setf = byte_end & (phase == NFSB_DAT) & (opc == `NFSB_OP_SETF);
    // R1: lock with wp low
    wire prot_lock = prot[`NFSB_BIT_LOCK] & ~wp_s[1];
    wire apb_wr = i_psel & i_penable & i_pwrite & o_pready;

    function automatic logic [7:0] rd_feat(input logic [7:0] a);
        // R16: addressed status byte
        case (a)
            `NFSB_FA_PROT: rd_feat = prot;
            `NFSB_FA_FEAT: rd_feat = feat;
            `NFSB_FA_STAT: rd_feat = {2'b00, eccst[3:2], pfail, efail, 2'b00};
            `NFSB_FA_STAT2: rd_feat = {2'b00, eccst[1:0], 4'h0};
            default: rd_feat = 8'h00;
        endcase
    endfunction : rd_feat

    // spi byte framing
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            shreg <= 8'h00;
            bitcnt <= 3'h0;
            phase <= NFSB_OP;
            opc <= 8'h00;
            fadr <= 8'h00;
        end
        else if (!sel)
        begin
            bitcnt <= 3'h0;
            phase <= NFSB_OP;
        end
        else if (rise)
        begin
            shreg <= nbyte;
            bitcnt <= bitcnt + 3'h1;
            if (bitcnt == 3'h7)
            begin
                case (phase)
                    NFSB_OP:
                    begin
                        opc <= nbyte;
                        phase <= NFSB_ADR;
                    end
                    NFSB_ADR:
                    begin
                        fadr <= nbyte;
                        phase <= NFSB_DAT;
                    end
                    NFSB_DAT: phase <= NFSB_DONE;
                    default: phase <= NFSB_DONE;
                endcase
            end
        end
    end

    // get features output
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            txbyte <= 8'h00;
            o_miso <= 1'b0;
            o_miso_oe <= 1'b0;
        end
        else
        begin
            o_miso_oe <= sel & (phase == NFSB_DAT) & (opc == `NFSB_OP_GETF);
            if (byte_end & (phase == NFSB_ADR))
                txbyte <= rd_feat(nbyte);
            else if (fall & (phase == NFSB_DAT))
            begin
                o_miso <= txbyte[7];
                txbyte <= {txbyte[6:0], 1'b0};
            end
        end
    end

    // feature writes
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            // R2: power-up protection
            prot <= `NFSB_PROT_RST;
            // R3: R4: R6: power-up features
            feat <= `NFSB_FEAT_RST;
        end
        else if (setf)
        begin
            // R1: R17: guarded protect write
            if (fadr == `NFSB_FA_PROT && !prot_lock)
                prot <= nbyte & `NFSB_PROT_MASK;
            // R5: R18: feature byte write
            if (fadr == `NFSB_FA_FEAT)
                feat <= nbyte & `NFSB_FEAT_MASK;
        end
    end

    // R6: quad gate
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_quad_grant <= 1'b0;
            o_ecc_active <= 1'b1;
        end
        else
        begin
            o_quad_grant <= i_quad_req & feat[`NFSB_BIT_QE];
            // R5: R9: ecc off path
            o_ecc_active <= feat[`NFSB_BIT_ECC];
        end
    end

    // ecc status
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            eccst <= 4'h0;
            por_done <= 1'b0;
        end
        else if (soft_rst || prd)
            // R7: zero on reset or read
            eccst <= 4'h0;
        else if (i_read_done)
        begin
            // R8: R10: load result
            eccst <= i_read_result;
            por_done <= 1'b1;
        end
    end

    // fail flags, set wins
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pfail <= 1'b0;
            efail <= 1'b0;
        end
        else
        begin
            // R11: R12: R13: program fail
            if (i_prog_fail || i_prot_prog)
                pfail <= 1'b1;
            else if (pexe || soft_rst)
                pfail <= 1'b0;
            // R14: R15: erase fail
            if (i_erase_fail || i_locked_erase)
                efail <= 1'b1;
            else if (bers || soft_rst)
                efail <= 1'b0;
        end
    end

    wire [4:0] evt = {i_read_done, setf, soft_rst, 1'b0,
        i_prog_fail | i_prot_prog | i_erase_fail | i_locked_erase};

    // apb registers and irq
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            irqs <= 5'h00;
            irqm <= 5'h00;
            host_fadr <= 8'h00;
            o_irq <= 1'b0;
            o_prdata <= 32'h00000000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end
        else
        begin
            irqs <= evt | (irqs & ~((apb_wr &&
                i_paddr == `NFSB_ADDR_IRQS) ? i_pwdata[4:0] : 5'h00));
            if (apb_wr && i_paddr == `NFSB_ADDR_IRQM)
                irqm <= i_pwdata[4:0];
            if (apb_wr && i_paddr == `NFSB_ADDR_FADR)
                host_fadr <= i_pwdata[7:0];
            o_irq <= |(irqs & irqm);
            o_pready <= i_psel & i_penable & ~o_pready;
            o_pslverr <= 1'b0;
            if (i_psel && i_penable && !o_pready)
            begin
                case (i_paddr)
                    `NFSB_ADDR_PROT: o_prdata <= {24'h0, prot};
                    `NFSB_ADDR_FEAT: o_prdata <= {24'h0, feat};
                    `NFSB_ADDR_STAT: o_prdata <= {24'h0, rd_feat(`NFSB_FA_STAT)};
                    `NFSB_ADDR_EVT: o_prdata <= {31'h0, por_done};
                    `NFSB_ADDR_FADR: o_prdata <= {24'h0, rd_feat(host_fadr)};
                    `NFSB_ADDR_IRQS: o_prdata <= {27'h0, irqs};
                    `NFSB_ADDR_IRQM: o_prdata <= {27'h0, irqm};
                    default:
                    begin
                        o_prdata <= 32'h00000000;
                        o_pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // R1: locked protect unchanged
    a_prot_lock_hold: assert property (@(posedge i_ref_clk) // R1
        disable iff (!i_reset_n) $past(prot_lock) |-> prot == $past(prot))
        else $error("protect changed while locked");
    // R1: unlocked write lands
    a_prot_write: assert property (@(posedge i_ref_clk) // R1
        disable iff (!i_reset_n) setf && fadr == `NFSB_FA_PROT && !prot_lock
        |=> prot == ($past(nbyte) & `NFSB_PROT_MASK))
        else $error("protect write lost");
    // R5: R18: feature write lands
    a_feat_write: assert property (@(posedge i_ref_clk) // R5
        disable iff (!i_reset_n) setf && fadr == `NFSB_FA_FEAT
        |=> feat == ($past(nbyte) & `NFSB_FEAT_MASK))
        else $error("feature write lost");
    // R3: R4: R6: soft reset keeps features
    a_feat_srst_keep: assert property (@(posedge i_ref_clk) // R3
        disable iff (!i_reset_n) soft_rst |=> feat == $past(feat))
        else $error("features changed by soft reset");
    // R7: zero after soft reset
    a_ecc_srst_zero: assert property (@(posedge i_ref_clk) // R7
        disable iff (!i_reset_n) soft_rst |=> eccst == 4'h0)
        else $error("ecc status not zeroed");
    // R7: zero at read start
    a_ecc_read_zero: assert property (@(posedge i_ref_clk) // R7
        disable iff (!i_reset_n) prd |=> eccst == 4'h0)
        else $error("ecc status not zeroed at read");
    // R8: loaded after read
    a_ecc_load: assert property (@(posedge i_ref_clk) // R8
        disable iff (!i_reset_n) i_read_done && !soft_rst && !prd
        |=> eccst == $past(i_read_result))
        else $error("ecc status not loaded");
    // R11: program fail sets
    a_pfail_set: assert property (@(posedge i_ref_clk) // R11
        disable iff (!i_reset_n) i_prog_fail |=> pfail)
        else $error("program fail not set");
    // R12: protected program sets
    a_pfail_prot: assert property (@(posedge i_ref_clk) // R12
        disable iff (!i_reset_n) i_prot_prog |=> pfail)
        else $error("protected program not flagged");
    // R13: cleared by execute
    a_pfail_clear: assert property (@(posedge i_ref_clk) // R13
        disable iff (!i_reset_n) pexe && !i_prog_fail && !i_prot_prog
        |=> !pfail) else $error("pfail not cleared");
    // R13: cleared by soft reset
    a_pfail_srst: assert property (@(posedge i_ref_clk) // R13
        disable iff (!i_reset_n) soft_rst && !i_prog_fail && !i_prot_prog
        |=> !pfail) else $error("pfail not cleared by reset");
    // R14: erase fail sets
    a_efail_set: assert property (@(posedge i_ref_clk) // R14
        disable iff (!i_reset_n) i_erase_fail || i_locked_erase |=> efail)
        else $error("erase fail not set");
    // R15: cleared by erase start
    a_efail_clear: assert property (@(posedge i_ref_clk) // R15
        disable iff (!i_reset_n) (bers || soft_rst) && !i_erase_fail
        && !i_locked_erase |=> !efail) else $error("efail not cleared");
    // R6: quad follows enable
    a_quad_gate: assert property (@(posedge i_ref_clk) // R6
        disable iff (!i_reset_n) o_quad_grant |-> $past(feat[`NFSB_BIT_QE]))
        else $error("quad without enable");
endmodule : nfsb_top
`default_nettype wire

// File: nfsb_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "nfsb_regs.svh"
module nfsb_top_test;
    logic clk, rst_n, psel, penable, pwrite, wp_n, quad_req, slv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [4:0] ev;
    logic [3:0] res;
    logic sclk, cs_n, mosi, miso, miso_oe, pready, pslverr, grant, ecc_on, irq;
    logic [7:0] b;
    int err_total, comparisons, seed, m_prot, m_feat, m_ecc, m_pf, m_ef;
    int oe_cnt = 0;
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (miso_oe === 1'b1)
            oe_cnt++;
    end
    nfsb_top dut_u (.i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
        .i_wp_n(wp_n), .o_miso(miso), .o_miso_oe(miso_oe),
        .i_prog_fail(ev[0]), .i_prot_prog(ev[1]), .i_erase_fail(ev[2]),
        .i_locked_erase(ev[3]), .i_read_done(ev[4]), .i_read_result(res),
        .i_quad_req(quad_req), .o_quad_grant(grant),
        .o_ecc_active(ecc_on), .o_irq(irq));
    nfsb_spi_host host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
        .i_miso(miso));
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [7:0] r);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
        begin
            err_total++;
            test_done();
        end
        r = prdata[7:0];
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic check_all;
        apb(1'b0, `NFSB_ADDR_PROT, 0, b);
        chk(b, 8'(m_prot));
        apb(1'b0, `NFSB_ADDR_FEAT, 0, b);
        chk(b, 8'(m_feat));
        apb(1'b0, `NFSB_ADDR_STAT, 0, b);
        chk(b & 8'h3C, 8'((m_ecc << 4) | (m_pf << 3) | (m_ef << 2)));
    endtask : check_all
    task automatic pulse(input int k);
        @(posedge clk);
        ev <= 5'(1 << k);
        res <= 4'($random(seed));
        @(posedge clk);
        ev <= 5'h00;
        if (k == 4)
            m_ecc = res[3:2];
        m_pf = (k < 2) ? 1 : m_pf;
        m_ef = (k == 2 || k == 3) ? 1 : m_ef;
        repeat (2) @(posedge clk);
    endtask : pulse
    task automatic spi(input logic [23:0] f, input int n);
        host_u.xfer(f, n, b);
        repeat (4) @(posedge clk);
    endtask : spi
    initial
    begin
        seed = 81491;
        {err_total, comparisons, m_ecc, m_pf, m_ef} = 0;
        {rst_n, psel, penable, pwrite, paddr, pwdata, ev, res} = 0;
        {wp_n, quad_req} = 2'b11;
        m_prot = 8'h38;
        m_feat = 8'h10;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        check_all();
        chk({7'b0, grant}, 8'h00);
        chk({7'b0, ecc_on}, 8'h01);
        $display("test reset values ended");
        pulse(4);
        check_all();
        apb(1'b0, `NFSB_ADDR_EVT, 0, b);
        chk(b, 8'h01);
        spi({`NFSB_OP_GETF, `NFSB_FA_STAT, 8'h00}, 3);
        chk(b & 8'h3C, 8'(m_ecc << 4));
        chk(8'(oe_cnt), 8'h40);
        apb(1'b1, `NFSB_ADDR_FADR, 32'hC0, b);
        apb(1'b0, `NFSB_ADDR_FADR, 0, b);
        chk(b & 8'h3C, 8'(m_ecc << 4));
        $display("test power-on ecc ended");
        spi({`NFSB_OP_SETF, `NFSB_FA_FEAT, 8'h41}, 3);
        m_feat = 8'h41;
        check_all();
        chk({7'b0, ecc_on}, 8'h00);
        chk({7'b0, grant}, 8'h01);
        quad_req <= 1'b0;
        repeat (2) @(posedge clk);
        chk({7'b0, grant}, 8'h00);
        quad_req <= 1'b1;
        spi({`NFSB_OP_SETF, `NFSB_FA_PROT, 8'h80}, 3);
        m_prot = 8'h80;
        wp_n <= 1'b0;
        spi({`NFSB_OP_SETF, `NFSB_FA_PROT, 8'h38}, 3);
        check_all();
        wp_n <= 1'b1;
        spi({`NFSB_OP_SETF, `NFSB_FA_PROT, 8'h38}, 3);
        m_prot = 8'h38;
        check_all();
        $display("test features and lock ended");
        pulse(0);
        check_all();
        spi({`NFSB_OP_PEXE, 16'h0000}, 1);
        m_pf = 0;
        check_all();
        pulse(1);
        pulse(2);
        check_all();
        spi({`NFSB_OP_BERS, 16'h0000}, 1);
        m_ef = 0;
        check_all();
        pulse(3);
        spi({`NFSB_OP_PRD, 16'h0000}, 1);
        m_ecc = 0;
        check_all();
        pulse(4);
        pulse(0);
        check_all();
        spi({`NFSB_OP_SRST, 16'h0000}, 1);
        {m_ecc, m_pf, m_ef} = 0;
        check_all();
        $display("test fail flags ended");
        apb(1'b0, `NFSB_ADDR_IRQS, 0, b);
        chk(b & 8'h1F, 8'h1D);
        apb(1'b1, `NFSB_ADDR_IRQM, 32'h0, b);
        repeat (2) @(posedge clk);
        chk({7'b0, irq}, 8'h00);
        apb(1'b1, `NFSB_ADDR_IRQM, 32'h1F, b);
        repeat (2) @(posedge clk);
        chk({7'b0, irq}, 8'h01);
        apb(1'b1, `NFSB_ADDR_IRQS, 32'h1F, b);
        apb(1'b0, `NFSB_ADDR_IRQS, 0, b);
        chk(b & 8'h1F, 8'h00);
        chk({7'b0, irq}, 8'h00);
        apb(1'b0, 12'h01C, 0, b);
        chk({7'b0, slv}, 8'h01);
        $display("test interrupts ended");
        pulse(0);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        {m_ecc, m_pf, m_ef} = 0;
        m_prot = 8'h38;
        m_feat = 8'h10;
        check_all();
        apb(1'b0, `NFSB_ADDR_EVT, 0, b);
        chk(b, 8'h00);
        $display("test second reset ended");
        test_done();
    end
endmodule : nfsb_top_test
`default_nettype wire
